// ==== verilog/t8_timer.sv ====
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps

module t8_timer (
  // Clock and reset
  input  logic                      pclk,
  input  logic                      presetn,
  // APB slave
  input  logic                      psel,
  input  logic                      penable,
  input  logic                      pwrite,
  input  logic [t8_pkg::T8_AW-1:0]  paddr,
  input  logic [31:0]               pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Pins
  input  logic                      external_count_pin,
  input  logic                      port_direction_bit3,
  input  logic                      port_direction_bit4,
  output logic                      compare_a_output,
  output logic                      compare_a_oe,
  output logic                      compare_b_output,
  output logic                      compare_b_oe,
  // Interrupt
  output logic                      irq
);

  // ----------------------------------------------------------------
  // Waveform helpers
  // ----------------------------------------------------------------

  // Pin is connected unless the code is off or a reserved/disabled 01
  function automatic logic t8_drive_en(input t8_pkg::t8_wave_e cls, input logic [1:0] com,
                                       input logic is_a, input logic bit2);
    logic en;
    en = (com != 2'b00);
    if (com == 2'b01 && (cls == t8_pkg::T8_PHASE || cls == t8_pkg::T8_FAST)) begin
      en = is_a & bit2;
    end
    return en;
  endfunction : t8_drive_en

  // Next level of a compare output for one timer tick
  function automatic logic t8_oc_next(input logic oc, input t8_pkg::t8_wave_e cls,
                                      input logic [1:0] com, input logic is_a,
                                      input logic bit2, input logic up, input logic m,
                                      input logic bottom, input logic at_top);
    logic nx;
    nx = oc;
    unique case (cls)
      t8_pkg::T8_NORMAL, t8_pkg::T8_CTC: begin
        if (m) begin
          unique case (com)
            2'b01:   nx = ~oc;
            2'b10:   nx = 1'b0;
            2'b11:   nx = 1'b1;
            default: nx = oc;
          endcase
        end
      end
      t8_pkg::T8_FAST: begin
        if (bottom && com[1]) begin
          nx = ~com[0];
        end else if (m) begin
          unique case (com)
            2'b01:   nx = (is_a & bit2) ? ~oc : oc;
            2'b10:   nx = 1'b0;
            2'b11:   nx = 1'b1;
            default: nx = oc;
          endcase
        end
      end
      t8_pkg::T8_PHASE: begin
        if (m) begin
          unique case (com)
            2'b01:   nx = (is_a & bit2) ? ~oc : oc;
            2'b10:   nx = ~up;
            2'b11:   nx = up;
            default: nx = oc;
          endcase
        end else if (at_top && com[1]) begin
          nx = ~com[0];
        end
      end
    endcase
    return nx;
  endfunction : t8_oc_next

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  t8_pkg::t8_ctrl_s ctrl;
  logic [7:0]       cnt;
  logic [7:0]       cmp_a;
  logic [7:0]       cmp_b;
  logic [2:0]       iflag;
  logic [2:0]       imask;
  logic             up;
  logic             blocked;
  logic             tick;
  logic [7:0]       top;
  logic             is_pwm;
  logic             at_top;
  logic             wrap;
  logic             ovf_ev;
  logic             spec_a;
  logic             spec_b;
  logic             ma;
  logic             mb;
  logic             en_a;
  logic             en_b;
  logic             wr;
  logic             rd_setup;
  logic             mapped;
  logic [2:0]       next_iflag;

  t8_clk_sel u_clk_sel (
    .pclk               (pclk),
    .presetn            (presetn),
    .clock_select       (ctrl.clock_select),
    .external_count_pin (external_count_pin),
    .tick               (tick)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign mapped   = (paddr == t8_pkg::T8_OFF_CTRL)  || (paddr == t8_pkg::T8_OFF_CNT)   ||
                    (paddr == t8_pkg::T8_OFF_CMPA)  || (paddr == t8_pkg::T8_OFF_CMPB)  ||
                    (paddr == t8_pkg::T8_OFF_IFLAG) || (paddr == t8_pkg::T8_OFF_IMASK) ||
                    (paddr == t8_pkg::T8_OFF_PINS);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign wr       = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        t8_pkg::T8_OFF_CTRL:  prdata <= {22'h000000, ctrl};
        t8_pkg::T8_OFF_CNT:   prdata <= {24'h000000, cnt};
        t8_pkg::T8_OFF_CMPA:  prdata <= {24'h000000, cmp_a};
        t8_pkg::T8_OFF_CMPB:  prdata <= {24'h000000, cmp_b};
        t8_pkg::T8_OFF_IFLAG: prdata <= {29'h00000000, iflag};
        t8_pkg::T8_OFF_IMASK: prdata <= {29'h00000000, imask};
        t8_pkg::T8_OFF_PINS:  prdata <= {28'h0000000, en_b, compare_b_output,
                                         en_a, compare_a_output};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration and compare values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= t8_pkg::t8_ctrl_s'(t8_pkg::T8_CTRL_RST);
      cmp_a <= t8_pkg::T8_BYTE_RST;
      cmp_b <= t8_pkg::T8_BYTE_RST;
      imask <= t8_pkg::T8_IRQ_RST;
    end else if (wr) begin
      if (paddr == t8_pkg::T8_OFF_CTRL)  ctrl  <= t8_pkg::t8_ctrl_s'(pwdata[9:0]);
      if (paddr == t8_pkg::T8_OFF_CMPA)  cmp_a <= pwdata[7:0];
      if (paddr == t8_pkg::T8_OFF_CMPB)  cmp_b <= pwdata[7:0];
      if (paddr == t8_pkg::T8_OFF_IMASK) imask <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign is_pwm = (ctrl.waveform_mode == t8_pkg::T8_PHASE) ||
                  (ctrl.waveform_mode == t8_pkg::T8_FAST);
  assign top    = ((ctrl.waveform_mode == t8_pkg::T8_CTC) ||
                   (is_pwm && ctrl.waveform_mode_bit2)) ? cmp_a : t8_pkg::T8_MAX;
  assign at_top = tick && (cnt == top);
  // Fast PWM and CTC return to BOTTOM from TOP; normal mode wraps at MAX
  assign wrap   = at_top && (ctrl.waveform_mode != t8_pkg::T8_PHASE);
  assign ovf_ev = (ctrl.waveform_mode == t8_pkg::T8_PHASE) ?
                  (tick && !up && cnt == t8_pkg::T8_BOTTOM) :
                  (tick && cnt == t8_pkg::T8_MAX);

  // A software write wins over a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= t8_pkg::T8_BYTE_RST;
      up  <= 1'b1;
    end else if (wr && paddr == t8_pkg::T8_OFF_CNT) begin
      cnt <= pwdata[7:0];
    end else if (tick) begin
      if (ctrl.waveform_mode == t8_pkg::T8_PHASE) begin
        if (up && cnt >= top) begin
          up  <= 1'b0;
          cnt <= cnt - 8'h01;
        end else if (!up && cnt == t8_pkg::T8_BOTTOM) begin
          up  <= 1'b1;
          cnt <= cnt + 8'h01;
        end else begin
          cnt <= up ? cnt + 8'h01 : cnt - 8'h01;
        end
      end else begin
        cnt <= wrap ? t8_pkg::T8_BOTTOM : cnt + 8'h01;
      end
    end
  end

  // Match block lasts exactly until the next timer tick after a counter write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blocked <= 1'b0;
    end else if (wr && paddr == t8_pkg::T8_OFF_CNT) begin
      blocked <= 1'b1;
    end else if (tick) begin
      blocked <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Compare units
  // ----------------------------------------------------------------
  // Compare at TOP with the upper mode bit set is handled at BOTTOM in fast PWM, and at TOP in phase mode for A only
  assign spec_a = is_pwm && ctrl.compare_a_output_mode[1] && (cmp_a == top);
  assign spec_b = is_pwm && ctrl.compare_b_output_mode[1] && (cmp_b == top);
  assign ma     = tick && !blocked && (cnt == cmp_a) && !spec_a;
  assign mb     = tick && !blocked && (cnt == cmp_b) && !spec_b;

  assign en_a   = t8_drive_en(ctrl.waveform_mode, ctrl.compare_a_output_mode,
                              1'b1, ctrl.waveform_mode_bit2);
  assign en_b   = t8_drive_en(ctrl.waveform_mode, ctrl.compare_b_output_mode,
                              1'b0, ctrl.waveform_mode_bit2);

  // Driver is only on when software has also set the pin direction
  assign compare_a_oe = en_a & port_direction_bit3;
  assign compare_b_oe = en_b & port_direction_bit4;

  // Waveform generators; the level is kept even while disconnected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_output <= 1'b0;
    end else if (tick) begin
      compare_a_output <= t8_oc_next(compare_a_output, ctrl.waveform_mode,
                                     ctrl.compare_a_output_mode, 1'b1,
                                     ctrl.waveform_mode_bit2, up, ma, wrap,
                                     at_top && spec_a);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_b_output <= 1'b0;
    end else if (tick) begin
      compare_b_output <= t8_oc_next(compare_b_output, ctrl.waveform_mode,
                                     ctrl.compare_b_output_mode, 1'b0,
                                     ctrl.waveform_mode_bit2, up, mb, wrap,
                                     1'b0);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // Set beats write-one-to-clear, so an event in the clear cycle survives
  always_comb begin
    next_iflag = iflag;
    if (wr && paddr == t8_pkg::T8_OFF_IFLAG) begin
      next_iflag = iflag & ~pwdata[2:0];
    end
    next_iflag[t8_pkg::T8_IRQ_MA]  = next_iflag[t8_pkg::T8_IRQ_MA] | ma;
    next_iflag[t8_pkg::T8_IRQ_MB]  = next_iflag[t8_pkg::T8_IRQ_MB] | mb;
    next_iflag[t8_pkg::T8_IRQ_OVF] = next_iflag[t8_pkg::T8_IRQ_OVF] | ovf_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iflag <= t8_pkg::T8_IRQ_RST;
    end else begin
      iflag <= next_iflag;
    end
  end

  assign irq = |(iflag & imask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CS_STOP: assert property (ctrl.clock_select == t8_pkg::T8_CS_STOP |-> !tick)
    else $error("stopped timer ticked");
  AST_DIV8: assert property ((ctrl.clock_select == t8_pkg::T8_CS_DIV8 && tick)
    |=> (!tick || ctrl.clock_select != t8_pkg::T8_CS_DIV8) [*7])
    else $error("divide by 8 ticked early");
  AST_CNT_RD: assert property ((rd_setup && paddr == t8_pkg::T8_OFF_CNT)
    |=> prdata[7:0] == $past(cnt))
    else $error("counter read wrong");
  AST_BLOCK: assert property ((blocked && tick && iflag == t8_pkg::T8_IRQ_RST) |=>
    iflag[t8_pkg::T8_IRQ_MB:t8_pkg::T8_IRQ_MA] == 2'b00)
    else $error("match not blocked after counter write");
  AST_MATCH_A: assert property ((tick && !blocked && cnt == cmp_a && !spec_a)
    |=> iflag[t8_pkg::T8_IRQ_MA])
    else $error("compare A flag not set");
  AST_PH_A_UP: assert property ((ctrl.waveform_mode == t8_pkg::T8_PHASE &&
    ctrl.compare_a_output_mode == 2'b10 && ma && up) |=> !compare_a_output)
    else $error("phase A mode 10 did not clear");
  AST_PH_A_DN: assert property ((ctrl.waveform_mode == t8_pkg::T8_PHASE &&
    ctrl.compare_a_output_mode == 2'b11 && ma && !up) |=> !compare_a_output)
    else $error("phase A mode 11 did not clear");
  AST_PH_A_OFF: assert property ((ctrl.waveform_mode == t8_pkg::T8_PHASE &&
    ctrl.compare_a_output_mode == 2'b01 && !ctrl.waveform_mode_bit2) |-> !compare_a_oe)
    else $error("phase A mode 01 drove pin");
  AST_PH_A_TOP: assert property ((ctrl.waveform_mode == t8_pkg::T8_PHASE &&
    ctrl.compare_a_output_mode == 2'b10 && at_top && spec_a && up) |=> compare_a_output)
    else $error("phase A top action missing");
  AST_B_SET: assert property ((ctrl.waveform_mode == t8_pkg::T8_CTC &&
    ctrl.compare_b_output_mode == 2'b11 && mb) |=> compare_b_output)
    else $error("B mode 11 did not set");
  AST_FAST_B_BOT: assert property ((ctrl.waveform_mode == t8_pkg::T8_FAST &&
    ctrl.compare_b_output_mode == 2'b10 && wrap) |=> compare_b_output)
    else $error("fast B not set at bottom");
  AST_FAST_B_INV: assert property ((ctrl.waveform_mode == t8_pkg::T8_FAST &&
    ctrl.compare_b_output_mode == 2'b11 && mb && !wrap) |=> compare_b_output)
    else $error("fast B inverting did not set");
  AST_FAST_B_TOP: assert property ((ctrl.waveform_mode == t8_pkg::T8_FAST &&
    ctrl.compare_b_output_mode == 2'b11 && spec_b && at_top) |=> !compare_b_output)
    else $error("fast B top case not cleared at bottom");
  AST_B_OE: assert property ((ctrl.compare_b_output_mode != 2'b00 &&
    !(is_pwm && ctrl.compare_b_output_mode == 2'b01)) |-> compare_b_oe == port_direction_bit4)
    else $error("B override wrong");
  AST_RSV_B: assert property ((ctrl.waveform_mode == t8_pkg::T8_FAST &&
    ctrl.compare_b_output_mode == 2'b01) |-> !compare_b_oe)
    else $error("reserved B code drove pin");

  COV_FAST_B: cover property (ctrl.waveform_mode == t8_pkg::T8_FAST && mb ##[1:300] wrap);
  COV_PHASE:  cover property (ctrl.waveform_mode == t8_pkg::T8_PHASE && ma && !up);
  COV_BLOCK:  cover property (blocked && tick && cnt == cmp_a);
  COV_IRQ:    cover property (!irq ##1 irq);

endmodule : t8_timer

// ==== shared/t8_pkg.sv ====
package t8_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int          T8_AW         = 8;
  localparam logic [7:0]  T8_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  T8_OFF_CNT    = 8'h04;
  localparam logic [7:0]  T8_OFF_CMPA   = 8'h08;
  localparam logic [7:0]  T8_OFF_CMPB   = 8'h0c;
  localparam logic [7:0]  T8_OFF_IFLAG  = 8'h10;
  localparam logic [7:0]  T8_OFF_IMASK  = 8'h14;
  localparam logic [7:0]  T8_OFF_PINS   = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and fixed counter points
  // ----------------------------------------------------------------
  localparam logic [9:0]  T8_CTRL_RST   = 10'h000;
  localparam logic [7:0]  T8_BYTE_RST   = 8'h00;
  localparam logic [2:0]  T8_IRQ_RST    = 3'h0;
  localparam logic [7:0]  T8_BOTTOM     = 8'h00;
  localparam logic [7:0]  T8_MAX        = 8'hff;

  // Interrupt flag positions
  localparam int          T8_IRQ_MA     = 0;
  localparam int          T8_IRQ_MB     = 1;
  localparam int          T8_IRQ_OVF    = 2;

  // Prescaler tap masks: a tap fires when its low bits are all ones
  localparam logic [9:0]  T8_MASK_8     = 10'h007;
  localparam logic [9:0]  T8_MASK_64    = 10'h03f;
  localparam logic [9:0]  T8_MASK_256   = 10'h0ff;
  localparam logic [9:0]  T8_MASK_1024  = 10'h3ff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    T8_NORMAL = 2'b00,
    T8_PHASE  = 2'b01,
    T8_CTC    = 2'b10,
    T8_FAST   = 2'b11
  } t8_wave_e;

  typedef enum logic [2:0] {
    T8_CS_STOP = 3'b000,
    T8_CS_DIV1 = 3'b001,
    T8_CS_DIV8 = 3'b010,
    T8_CS_D64  = 3'b011,
    T8_CS_D256 = 3'b100,
    T8_CS_D1K  = 3'b101,
    T8_CS_FALL = 3'b110,
    T8_CS_RISE = 3'b111
  } t8_cs_e;

  typedef struct packed {
    logic [1:0] compare_a_output_mode;
    logic [1:0] compare_b_output_mode;
    t8_cs_e     clock_select;
    logic       waveform_mode_bit2;
    t8_wave_e   waveform_mode;
  } t8_ctrl_s;

endpackage : t8_pkg

// ==== verilog/t8_clk_sel.sv ====
`timescale 1ns/1ps

module t8_clk_sel (
  // Clock and reset
  input  logic             pclk,
  input  logic             presetn,
  // Selection
  input  t8_pkg::t8_cs_e   clock_select,
  // External count pin
  input  logic             external_count_pin,
  // One-cycle count enable
  output logic             tick
);

  // ----------------------------------------------------------------
  // Prescaler and pin synchroniser
  // ----------------------------------------------------------------
  logic [9:0] pre;
  logic       pin_s1;
  logic       pin_s2;
  logic       pin_s3;

  // Free-running prescaler shared by all divided taps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 10'h000;
    end else begin
      pre <= pre + 10'h001;
    end
  end

  // Two flops against metastability, a third for the edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= external_count_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Pin edges count even when the pin is an output, since only the pad level is seen
  always_comb begin
    unique case (clock_select)
      t8_pkg::T8_CS_STOP: tick = 1'b0;
      t8_pkg::T8_CS_DIV1: tick = 1'b1;
      t8_pkg::T8_CS_DIV8: tick = (pre & t8_pkg::T8_MASK_8) == t8_pkg::T8_MASK_8;
      t8_pkg::T8_CS_D64:  tick = (pre & t8_pkg::T8_MASK_64) == t8_pkg::T8_MASK_64;
      t8_pkg::T8_CS_D256: tick = (pre & t8_pkg::T8_MASK_256) == t8_pkg::T8_MASK_256;
      t8_pkg::T8_CS_D1K:  tick = (pre & t8_pkg::T8_MASK_1024) == t8_pkg::T8_MASK_1024;
      t8_pkg::T8_CS_FALL: tick = pin_s3 & ~pin_s2;
      t8_pkg::T8_CS_RISE: tick = pin_s2 & ~pin_s3;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EXT_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_select == t8_pkg::T8_CS_RISE && pin_s2 && !pin_s3) |-> tick)
    else $error("rising pin edge did not count");

endmodule : t8_clk_sel

// ==== bench/t8_pin_model.sv ====
`timescale 1ns/1ps
// Port pins outside the timer; a released pin floats to its pull-up
module t8_pin_model (
  // Timer side
  input  logic out_a,
  input  logic oe_a,
  input  logic out_b,
  input  logic oe_b,
  // Software request for the count pin
  input  logic count_req,
  // Pin levels
  output logic pin_a,
  output logic pin_b,
  output logic count_pin
);
  // Pull-up keeps a released pin from showing its last driven level
  assign pin_a = oe_a ? out_a : 1'b1;
  assign pin_b = oe_b ? out_b : 1'b1;
  // The pin is counted even while the port drives it
  assign count_pin = count_req;
endmodule : t8_pin_model

// ==== bench/t8_timer_bench.sv ====
`timescale 1ns/1ps
module t8_timer_bench;
  logic        pclk, presetn, psel, penable, pwrite, count_req, dir3, dir4;
  logic        pready, pslverr, err, irq, oa, oea, ob, oeb, pin_a, pin_b, cpin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  int          num_errors, tests_run;
  int          div [5] = '{1, 8, 64, 256, 1024};

  t8_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(cpin), .port_direction_bit3(dir3),
    .port_direction_bit4(dir4), .compare_a_output(oa), .compare_a_oe(oea),
    .compare_b_output(ob), .compare_b_oe(oeb), .irq(irq));
  t8_pin_model pins (.out_a(oa), .oe_a(oea), .out_b(ob), .oe_b(oeb), .count_req(count_req),
    .pin_a(pin_a), .pin_b(pin_b), .count_pin(cpin));

  // ----------------------------------------------------------------
  // Clock, bus tasks and verdict
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // One APB transfer; the #1 lets the completing edge settle before callers look
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk

  function automatic logic [31:0] ctl(input logic [1:0] a, input logic [1:0] b,
                                      input logic [2:0] cs, input logic b2,
                                      input logic [1:0] w);
    return {22'h0, a, b, cs, b2, w};
  endfunction : ctl

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Watchdog, well above the roughly 7500 cycles the tests need
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, count_req, presetn} = '0;
    dir3 = 1'b1;
    dir4 = 1'b1;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", 32'h0, d);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h5a);
    apb(1'b0, t8_pkg::T8_OFF_CNT, 32'h0);
    chk("counter", 32'h5a, d);
    $display("Test registers done");
    // Non-PWM modes of output B, one match at count 5 each
    apb(1'b1, t8_pkg::T8_OFF_CMPB, 32'h5);
    for (int m = 3; m >= 0; m--) begin
      apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h0);
      apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'(m), 3'h1, 1'b0, 2'h0));
      repeat (20) @(posedge pclk);
      apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'(m), 3'h0, 1'b0, 2'h0));
      chk("b enable", {31'h0, m != 0}, {31'h0, oeb});
      if (m != 0) chk("b pin", {31'h0, m != 2}, {31'h0, pin_b});
    end
    apb(1'b0, t8_pkg::T8_OFF_PINS, 32'h0);
    chk("pin status", 32'h4, d);
    apb(1'b0, t8_pkg::T8_OFF_IFLAG, 32'h0);
    chk("flags", 32'h2, d);
    apb(1'b1, t8_pkg::T8_OFF_IMASK, 32'h2);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, t8_pkg::T8_OFF_IMASK, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, t8_pkg::T8_OFF_IMASK, 32'h2);
    apb(1'b1, t8_pkg::T8_OFF_IFLAG, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // A counter write equal to the compare value hides the first match
    apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h5);
    apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'h3, 3'h1, 1'b0, 2'h0));
    repeat (20) @(posedge pclk);
    apb(1'b1, t8_pkg::T8_OFF_CTRL, 32'h0);
    apb(1'b0, t8_pkg::T8_OFF_IFLAG, 32'h0);
    chk("blocked match", 32'h0, d);
    $display("Test non-PWM done");
    // Fast PWM with TOP 0x60 from compare A, B matches at 0x40
    // Looked at from the second period on, so the match level follows an opposite BOTTOM action and the BOTTOM level an opposite match
    apb(1'b1, t8_pkg::T8_OFF_CMPA, 32'h60);
    apb(1'b1, t8_pkg::T8_OFF_CMPB, 32'h40);
    for (int m = 2; m <= 3; m++) begin
      apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h10);
      apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'(m), 3'h1, 1'b1, 2'h3));
      repeat (160) @(posedge pclk);
      chk("fast match", {31'h0, m == 3}, {31'h0, pin_b});
      repeat (40) @(posedge pclk);
      chk("fast bottom", {31'h0, m == 2}, {31'h0, pin_b});
    end
    apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'h1, 3'h0, 1'b1, 2'h3));
    chk("reserved b", 32'h0, {31'h0, oeb});
    $display("Test fast PWM done");
    // Phase-correct output A, TOP 0xff, compare at 0x40
    apb(1'b1, t8_pkg::T8_OFF_CMPA, 32'h40);
    apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h10);
    apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h3, 2'h0, 3'h1, 1'b0, 2'h1));
    repeat (56) @(posedge pclk);
    chk("phase up set", 32'h1, {31'h0, pin_a});
    chk("a enable", 32'h1, {31'h0, oea});
    repeat (400) @(posedge pclk);
    chk("phase down clear", 32'h0, {31'h0, pin_a});
    apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h2, 2'h0, 3'h1, 1'b0, 2'h1));
    repeat (500) @(posedge pclk);
    chk("phase down set", 32'h1, {31'h0, pin_a});
    repeat (120) @(posedge pclk);
    chk("phase up clear", 32'h0, {31'h0, pin_a});
    apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h1, 2'h0, 3'h0, 1'b0, 2'h1));
    chk("a mode one off", 32'h0, {31'h0, oea});
    $display("Test phase PWM done");
    // Compare A as TOP: CTC wraps there, phase acts at TOP, fast ignores a B match at TOP
    apb(1'b1, t8_pkg::T8_OFF_CMPA, 32'h20);
    apb(1'b1, t8_pkg::T8_OFF_CMPB, 32'h8);
    apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h0);
    apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'h3, 3'h1, 1'b0, 2'h2));
    repeat (50) @(posedge pclk);
    chk("ctc b set", 32'h1, {31'h0, pin_b});
    apb(1'b1, t8_pkg::T8_OFF_CTRL, 32'h0);
    apb(1'b0, t8_pkg::T8_OFF_CNT, 32'h0);
    chk("ctc wrap", 32'h14, d);
    apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h0);
    apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h2, 2'h0, 3'h1, 1'b1, 2'h1));
    repeat (50) @(posedge pclk);
    chk("phase top set", 32'h1, {31'h0, pin_a});
    apb(1'b1, t8_pkg::T8_OFF_CTRL, 32'h0);
    apb(1'b1, t8_pkg::T8_OFF_CMPB, 32'h20);
    apb(1'b1, t8_pkg::T8_OFF_IFLAG, 32'h7);
    apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h0);
    apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'h3, 3'h1, 1'b1, 2'h3));
    repeat (50) @(posedge pclk);
    chk("fast top b", 32'h0, {31'h0, pin_b});
    apb(1'b1, t8_pkg::T8_OFF_CTRL, 32'h0);
    apb(1'b0, t8_pkg::T8_OFF_IFLAG, 32'h0);
    chk("fast top flags", 32'h1, d);
    $display("Test compare at TOP done");
    // Prescaler taps: about four ticks in each window
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h0);
      apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'h0, 3'(i + 1), 1'b0, 2'h0));
      repeat (4 * div[i] - 3) @(posedge pclk);
      apb(1'b1, t8_pkg::T8_OFF_CTRL, 32'h0);
      apb(1'b0, t8_pkg::T8_OFF_CNT, 32'h0);
      tests_run++;
      if ((d >= 32'h3 && d <= 32'h5) !== 1'b1) begin
        $display("Error prescaled count expected 4 seen %h", d);
        num_errors++;
      end
    end
    $display("Test clock select done");
    // Count pin: three pulses counted on falls, then two on rises
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, t8_pkg::T8_OFF_CNT, 32'h0);
      apb(1'b1, t8_pkg::T8_OFF_CTRL, ctl(2'h0, 2'h0, 3'(6 + e), 1'b0, 2'h0));
      repeat (3 - e) begin
        repeat (6) @(posedge pclk);
        count_req <= 1'b1;
        repeat (6) @(posedge pclk);
        count_req <= 1'b0;
      end
      // The last edge is counted three clocks late, behind the synchroniser
      repeat (6) @(posedge pclk);
      apb(1'b0, t8_pkg::T8_OFF_CNT, 32'h0);
      chk("pin count", 32'(3 - e), d);
    end
    $display("Test count pin done");
    print_verdict();
  end
endmodule : t8_timer_bench
